// ===== design/sdwp_pkg.sv
`default_nettype none
package sdwp_pkg;
    // Field widths
    localparam int LEN_W = 8;
    localparam int ADDR_W = 16;
    localparam int CNT_W = 9;
    // Serial clock divider: four system clocks per serial bit
    localparam logic [1:0] DIV_RISE = 2'h2;
    localparam logic [1:0] DIV_LAST = 2'h3;
    localparam logic [2:0] BIT_LAST = 3'h7;
    // Byte buffer depth
    localparam int BUF_DEPTH = 4;
    localparam int PTR_W = 2;
    localparam logic [2:0] BUF_FULL = 3'h4;
    // Memory arbitration class of this port
    localparam logic [1:0] PRIO_LOWEST = 2'h0;
    // Counter reset value and increment step
    localparam logic [CNT_W-1:0] CNT_ZERO = 9'h000;
    localparam logic [CNT_W-1:0] CNT_ONE = 9'h001;

    // Shifter states, Gray along IDLE-WAIT-LATCH-SHIFT
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_WAIT = 3'h1,
        ST_LATCH = 3'h3,
        ST_SHIFT = 3'h2,
        ST_RST = 3'h6
    } sdwp_state_e;
endpackage
`default_nettype wire

// ===== design/sdwp_buf_if.sv
`default_nettype none
interface sdwp_buf_if;
    logic pushValid;
    logic [7:0] pushData;
    logic full;
    logic popReady;
    logic [7:0] popData;
    logic empty;
    modport buffer (input pushValid, pushData, popReady,
                    output full, popData, empty);
    modport user (output pushValid, pushData, popReady,
                  input full, popData, empty);
endinterface
`default_nettype wire

// ===== design/sdwp_byte_buf.sv
`default_nettype none
module sdwp_byte_buf
    import sdwp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic flush,
    sdwp_buf_if.buffer bus
);
    logic [7:0] mem [BUF_DEPTH];
    logic [PTR_W-1:0] wrPtr_q;
    logic [PTR_W-1:0] rdPtr_q;
    logic [2:0] cnt_q;
    logic [7:0] popData_q;
    wire doPush;
    wire doPop;

    // Handshake decode
    assign doPush = bus.pushValid && !bus.full;
    assign doPop = bus.popReady && !bus.empty;
    assign bus.full = (cnt_q == BUF_FULL);
    assign bus.empty = (cnt_q == 3'h0);
    assign bus.popData = popData_q;

    // Storage, one write enable per entry
    for (genvar i = 0; i < BUF_DEPTH; i++) begin : gEntry
        always_ff @(posedge clk) begin
            if (doPush && wrPtr_q == PTR_W'(i)) begin
                mem[i] <= bus.pushData;
            end
        end
    end

    // Pointers and fill level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            cnt_q <= 3'h0;
            popData_q <= 8'h00;
        end else if (flush) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            cnt_q <= 3'h0;
        end else begin
            wrPtr_q <= wrPtr_q + PTR_W'(doPush);
            rdPtr_q <= rdPtr_q + PTR_W'(doPop);
            cnt_q <= cnt_q + 3'(doPush) - 3'(doPop);
            if (doPop) begin
                popData_q <= mem[rdPtr_q];
            end
        end
    end
endmodule
`default_nettype wire

// ===== design/sdwp_port.sv
`default_nettype none
module sdwp_port
    import sdwp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cfgWrite,
    input wire logic [ADDR_W-1:0] cfgOffset,
    input wire logic cfgTrigger,
    input wire logic [LEN_W-1:0] cmdLen,
    input wire logic [LEN_W-1:0] dataLen,
    input wire logic altSelect,
    input wire logic resetReq,
    output logic memReq,
    output logic [ADDR_W-1:0] memAddr,
    output logic [1:0] memPrio,
    input wire logic memGrant,
    input wire logic memRdValid,
    input wire logic [7:0] memRdData,
    output logic panelSelectN,
    output logic panelCmd,
    output logic panelClk,
    output logic panelDout,
    output logic panelResetN,
    output logic altSelectPinOut,
    output logic altSelectPinOe,
    output logic active,
    output logic irq
);
    sdwp_state_e state_q;
    sdwp_state_e state_d;
    logic trigPulse_q;
    logic [ADDR_W-1:0] offset_q;
    logic [LEN_W-1:0] cmdLen_q;
    logic [CNT_W-1:0] total_q;
    logic [CNT_W-1:0] fetchCnt_q;
    logic [CNT_W-1:0] sentCnt_q;
    logic pending_q;
    logic [1:0] divCnt_q;
    logic [2:0] bitCnt_q;
    logic [7:0] shift_q;
    logic sel_q;
    logic cmd_q;
    logic clk_q;
    logic dout_q;
    logic rstN_q;
    logic alt_q;
    logic irq_q;
    logic [ADDR_W-1:0] memAddr_q;
    sdwp_buf_if bufIf ();
    // Decode of progress
    wire busy = (state_q != ST_IDLE) && (state_q != ST_RST);
    wire allSent = (sentCnt_q == total_q);
    wire byteEnd = (state_q == ST_SHIFT) && (divCnt_q == DIV_LAST)
        && (bitCnt_q == BIT_LAST);
    wire isData = (sentCnt_q >= {1'b0, cmdLen_q});
    wire fetchMore = busy && (fetchCnt_q != total_q);

    // Memory request side, lowest arbitration class
    assign memReq = fetchMore && !pending_q && !bufIf.full;
    assign memPrio = PRIO_LOWEST;
    assign memAddr = memAddr_q;
    assign bufIf.pushValid = memRdValid;
    assign bufIf.pushData = memRdData;
    assign bufIf.popReady = (state_q == ST_WAIT) && !allSent;
    sdwp_byte_buf uBuf (
        .clk(clk),
        .rst_n(rst_n),
        .flush(trigPulse_q),
        .bus(bufIf.buffer)
    );

    // Pin outputs and select routing
    assign panelSelectN = alt_q ? 1'b1 : sel_q;
    assign altSelectPinOut = sel_q;
    assign altSelectPinOe = alt_q;
    assign panelCmd = cmd_q;
    assign panelClk = clk_q;
    assign panelDout = dout_q;
    assign panelResetN = rstN_q;
    assign active = busy;
    assign irq = irq_q;

    // One-clock trigger pulse after the offset write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trigPulse_q <= 1'b0;
        end else begin
            trigPulse_q <= cfgWrite && cfgTrigger && !trigPulse_q;
        end
    end

    // Offset latched on each write, lengths at the trigger; route only while not busy (idle or panel reset)
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            offset_q <= '0;
            cmdLen_q <= '0;
            total_q <= CNT_ZERO;
            alt_q <= 1'b0;
        end else begin
            if (cfgWrite) begin
                offset_q <= cfgOffset;
            end
            if (trigPulse_q) begin
                cmdLen_q <= cmdLen;
                total_q <= CNT_W'(cmdLen) + CNT_W'(dataLen);
            end
            if (!busy) begin
                alt_q <= altSelect;
            end
        end
    end

    // Fetch counter and single outstanding read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fetchCnt_q <= CNT_ZERO;
            pending_q <= 1'b0;
            memAddr_q <= '0;
        end else if (trigPulse_q) begin
            fetchCnt_q <= CNT_ZERO;
            pending_q <= 1'b0;
            memAddr_q <= offset_q;
        end else begin
            if (memReq && memGrant) begin
                fetchCnt_q <= fetchCnt_q + CNT_ONE;
                memAddr_q <= memAddr_q + ADDR_W'(1);
                pending_q <= 1'b1;
            end else if (memRdValid) begin
                pending_q <= 1'b0;
            end
        end
    end

    // Shifter state machine
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (resetReq) begin
                    state_d = ST_RST;
                end else if (trigPulse_q) begin
                    state_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (allSent) begin
                    state_d = ST_IDLE;
                end else if (resetReq) begin
                    state_d = ST_RST;
                end else if (!bufIf.empty) begin
                    state_d = ST_LATCH;
                end
            end
            ST_LATCH: begin
                state_d = ST_SHIFT;
            end
            ST_SHIFT: begin
                if (byteEnd) begin
                    state_d = ST_WAIT;
                end
            end
            ST_RST: begin
                if (!resetReq) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end
    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Byte counter and clock divider
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sentCnt_q <= CNT_ZERO;
            divCnt_q <= 2'h0;
            bitCnt_q <= 3'h0;
        end else begin
            if (trigPulse_q) begin
                sentCnt_q <= CNT_ZERO;
            end else if (byteEnd) begin
                sentCnt_q <= sentCnt_q + CNT_ONE;
            end
            if (state_q == ST_SHIFT) begin
                divCnt_q <= divCnt_q + 2'h1;
                if (divCnt_q == DIV_LAST) begin
                    bitCnt_q <= bitCnt_q + 3'h1;
                end
            end else begin
                divCnt_q <= 2'h0;
                bitCnt_q <= 3'h0;
            end
        end
    end

    // Serial pins: data moves on falling edge, panel samples rising
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_q <= 8'h00;
            dout_q <= 1'b0;
            clk_q <= 1'b0;
            cmd_q <= 1'b0;
        end else if (state_q == ST_LATCH) begin
            shift_q <= bufIf.popData;
            dout_q <= bufIf.popData[7];
            cmd_q <= isData;
            clk_q <= 1'b0;
        end else if (state_q == ST_SHIFT) begin
            if (divCnt_q == DIV_RISE) begin
                clk_q <= 1'b1;
            end else if (divCnt_q == DIV_LAST) begin
                clk_q <= 1'b0;
                shift_q <= {shift_q[6:0], 1'b0};
                dout_q <= shift_q[6];
            end
        end else begin
            clk_q <= 1'b0;
        end
    end

    // Select, panel reset and end-of-transfer interrupt
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_q <= 1'b1;
            rstN_q <= 1'b1;
            irq_q <= 1'b0;
        end else begin
            if (state_q == ST_LATCH) begin
                sel_q <= 1'b0;
            end else if (state_d == ST_IDLE || state_d == ST_RST) begin
                sel_q <= 1'b1;
            end
            rstN_q <= (state_d != ST_RST);
            if (state_q == ST_WAIT && allSent) begin
                irq_q <= 1'b1;
            end else if (trigPulse_q) begin
                irq_q <= 1'b0;
            end
        end
    end

    // Checks
    chk_trig_single: assert property (@(posedge clk) disable iff (!rst_n)
        trigPulse_q |=> !trigPulse_q)
        else $error("trigger pulse longer than one clock");
    chk_irq_clear: assert property (@(posedge clk) disable iff (!rst_n)
        trigPulse_q |=> !irq)
        else $error("interrupt not cleared by trigger");
    chk_clk_idle: assert property (@(posedge clk) disable iff (!rst_n)
        !active |-> !panelClk)
        else $error("serial clock toggles while idle");
    chk_sel_shift: assert property (@(posedge clk) disable iff (!rst_n)
        state_q == ST_SHIFT |-> !sel_q && active)
        else $error("select high while shifting");
    chk_msb_first: assert property (@(posedge clk) disable iff (!rst_n)
        state_q == ST_LATCH |=> panelDout == $past(bufIf.popData[7]))
        else $error("first bit is not the MSB");
    chk_cmd_flag: assert property (@(posedge clk) disable iff (!rst_n)
        state_q == ST_SHIFT |-> panelCmd == isData)
        else $error("command flag wrong for byte kind");
    chk_reset_byte: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(panelResetN) |-> $past(state_q) != ST_SHIFT)
        else $error("panel reset cut a byte");
    chk_req_bound: assert property (@(posedge clk) disable iff (!rst_n)
        memReq |-> fetchCnt_q < total_q && memPrio == PRIO_LOWEST)
        else $error("memory request beyond programmed length");
    chk_byte_count: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(irq) |-> sentCnt_q == total_q && sel_q)
        else $error("transfer ended with wrong byte count");
    chk_bit_period: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(panelClk) |=> !panelClk [*3])
        else $error("serial clock high time wrong");
endmodule
`default_nettype wire

// ===== verif/sdwp_panel_model.sv
`default_nettype none
module sdwp_panel_model (
    input wire logic selN,
    input wire logic panelCmd,
    input wire logic panelClk,
    input wire logic panelDout,
    input wire logic panelResetN
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [8:0] rxQ [$];
    logic [7:0] sh = 8'h00;
    int nBits = 0;
    int nBad = 0;
    int nStray = 0;
    int nSlow = 0;
    realtime lastRise = 0.0;
    // Longest bit spacing: eight system clocks of 25 ns
    localparam realtime MAX_GAP = 200.0;

    // Panel captures a bit on each rising serial clock while selected
    always @(posedge panelClk) begin
        if (!selN && panelResetN) begin
            if (nBits % 8 != 0 && $realtime - lastRise > MAX_GAP) begin
                nSlow++;
            end
            lastRise = $realtime;
            sh = {sh[6:0], panelDout};
            nBits++;
            if (nBits % 8 == 0) begin
                rxQ.push_back({panelCmd, sh});
            end
        end else begin
            nStray++;
        end
    end

    // Deselect in mid-byte leaves a split byte
    always @(posedge selN) begin
        if (nBits % 8 != 0) begin
            nBad++;
        end
        nBits = 0;
    end
endmodule
`default_nettype wire

// ===== verif/tb_serial_display_write_port.sv
`default_nettype none
module tb_serial_display_write_port
    import sdwp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {
        logic [7:0] c;
        logic [7:0] d;
        logic [15:0] off;
        int gap;
        int lat;
        logic alt;
    } sdwp_row_s;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cfgWrite = 1'b0, cfgTrigger = 1'b0;
    logic altSelect = 1'b0, resetReq = 1'b0;
    logic [15:0] cfgOffset = 16'h0000;
    logic [7:0] cmdLen = 8'h00, dataLen = 8'h00;
    logic memGrant = 1'b0, memRdValid = 1'b0;
    logic [7:0] memRdData = 8'h00;
    logic memReq, panelSelectN, panelCmd, panelClk, panelDout;
    logic panelResetN, altSelectPinOut, altSelectPinOe, active, irq;
    logic selN;
    logic [15:0] memAddr;
    logic [1:0] memPrio;
    logic [15:0] rAddr = 16'h0000;
    int mismatches = 0, nChecks = 0, cyc = 0, pend = 0, gap = 1, lat = 1;
    sdwp_row_s rows [6] = '{
        '{8'h01, 8'h04, 16'h0100, 1, 1, 1'b0},
        '{8'h02, 8'h05, 16'h0200, 3, 6, 1'b1},
        '{8'h00, 8'h03, 16'h0300, 1, 2, 1'b0},
        '{8'h03, 8'h00, 16'h0400, 2, 1, 1'b0},
        '{8'h00, 8'h00, 16'h0500, 1, 1, 1'b0},
        '{8'hFF, 8'hFF, 16'hFFF0, 1, 3, 1'b0}};

    // Select seen by the panel follows the routed pin
    assign selN = altSelectPinOe ? altSelectPinOut : panelSelectN;

    sdwp_port sdwp_port_inst (.clk, .rst_n, .cfgWrite, .cfgOffset,
        .cfgTrigger, .cmdLen, .dataLen, .altSelect, .resetReq, .memReq,
        .memAddr, .memPrio, .memGrant, .memRdValid, .memRdData,
        .panelSelectN, .panelCmd, .panelClk, .panelDout, .panelResetN,
        .altSelectPinOut, .altSelectPinOe, .active, .irq);

    sdwp_panel_model panel_model_inst (.selN, .panelCmd, .panelClk,
        .panelDout, .panelResetN);

    always #12.5 clk = ~clk;

    function automatic logic [7:0] memByte(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5A;
    endfunction

    task automatic check(input logic ok, input string msg);
        nChecks++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask

    task automatic complete_run();
        if (mismatches == 0 && nChecks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Memory grants every gap cycles and answers lat cycles later
    always @(posedge clk) begin
        cyc <= cyc + 1;
        memGrant <= (cyc % gap == 0);
        memRdValid <= 1'b0;
        if (pend == 1) begin
            memRdValid <= 1'b1;
            memRdData <= memByte(rAddr);
        end
        if (pend > 0) begin
            pend <= pend - 1;
        end
        if (memReq === 1'b1 && memGrant) begin
            rAddr <= memAddr;
            pend <= lat;
            check(memPrio === PRIO_LOWEST, "priority class");
        end
    end

    task automatic trigger(input sdwp_row_s r);
        cfgOffset <= r.off;
        cmdLen <= r.c;
        dataLen <= r.d;
        cfgWrite <= 1'b1;
        cfgTrigger <= 1'b1;
        @(posedge clk);
        cfgWrite <= 1'b0;
        cfgTrigger <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        if ((r.c | r.d) != 8'h00) begin
            check(active === 1'b1, "active not raised");
            check(irq === 1'b0, "irq not cleared");
        end
    endtask

    task automatic waitDone();
        for (int k = 0; k < 30000 && irq !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        check(irq === 1'b1, "transfer never ended");
    endtask

    task automatic runRow(input sdwp_row_s r);
        int n;
        logic [8:0] exp;
        n = r.c + r.d;
        gap = r.gap;
        lat = r.lat;
        altSelect <= r.alt;
        panel_model_inst.rxQ.delete();
        @(posedge clk);
        trigger(r);
        waitDone();
        @(posedge clk);
        #1;
        check(active === 1'b0 && selN === 1'b1, "select held");
        check(panel_model_inst.rxQ.size() == n, "byte count");
        for (int i = 0; i < panel_model_inst.rxQ.size(); i++) begin
            exp = {i >= r.c, memByte(r.off + 16'(i))};
            check(panel_model_inst.rxQ[i] === exp, "byte");
        end
        @(posedge clk);
    endtask

    // Reset values, table rows, then panel reset requested in mid-byte
    initial begin
        repeat (20) @(posedge clk);
        check(panelSelectN === 1'b1 && panelResetN === 1'b1 &&
            panelClk === 1'b0 && irq === 1'b0 && active === 1'b0 &&
            memReq === 1'b0, "reset values");
        rst_n <= 1'b1;
        foreach (rows[i]) runRow(rows[i]);
        panel_model_inst.rxQ.delete();
        trigger(rows[1]);
        @(posedge clk);
        altSelect <= 1'b1;
        for (int k = 0; k < 2000 && panel_model_inst.nBits != 11; k++)
            @(posedge clk);
        #1;
        check(altSelectPinOe === 1'b0, "routing moved");
        resetReq <= 1'b1;
        for (int k = 0; k < 2000 && panelResetN !== 1'b0; k++)
            @(posedge clk);
        #1;
        check(panel_model_inst.rxQ.size() == 2, "byte cut");
        repeat (8) @(posedge clk);
        resetReq <= 1'b0;
        repeat (8) @(posedge clk);
        #1;
        check(panelResetN === 1'b1 && irq === 1'b0, "reset exit");
        check(altSelectPinOe === 1'b1, "routing not applied");
        check(panel_model_inst.nBad == 0, "split byte");
        check(panel_model_inst.nStray == 0, "stray clock");
        check(panel_model_inst.nSlow == 0, "bit period");
        complete_run();
    end

    // Watchdog against a hang
    initial begin
        repeat (90000) @(posedge clk);
        mismatches++;
        complete_run();
    end
endmodule
`default_nettype wire
